/* File: tmb_temp.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tmb_map.svh"
module tmb_temp #(
    parameter int PRIO_W = `TMB_PRIO_W
) (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic         bus_needed_i,
    input  wire tmb_pkg::prio_t prio_sw_i,
    input  wire logic         cycles_done_i,
    tmb_if.temp               bus,
    output logic              mine_o,
    output logic              cycle_start_o
);
    import tmb_pkg::*;

    // ----------------------------------------
    // state record
    // ----------------------------------------
    // *_s1/_s2 pairs are two-flop synchronisers; ack_q2 delays the
    // synchronised acknowledge once more so its rise reads as an edge
    typedef struct packed {
        tm_state_e st;
        cnt_t      cnt;
        logic      req;
        logic      drive;
        logic      asd_dis;
        logic      ctl_dis;
        logic      ctl_en;
        logic      start;
        logic      win_s1;
        logic      win_s2;
        logic      ack_s1;
        logic      ack_s2;
        logic      ack_q2;
        logic      hold_s1;
        logic      hold_s2;
    } tm_s;
    tm_s               q, d;
    prio_t             keep;
    logic [PRIO_W-1:0] clash;
    logic              win;

    // ----------------------------------------
    // arbitration compare
    // ----------------------------------------
    // asynchronous on purpose: every requester settles in the gap
    // between request and acknowledge, so no clock is spent here
    // keep stays all ones with no rival on the lines
    always_comb begin
        clash = '0;
        keep = '1;
        for (int i = PRIO_W - 1; i >= 0; i--) begin
            // line pulled low while our switch is open: a stronger requester
            clash[i] = !bus.arb_n[i] && !prio_sw_i[i];
        end
        for (int i = PRIO_W - 1; i >= 0; i--) begin
            if (clash[i]) begin
                for (int j = 0; j < i; j++) begin
                    keep[j] = 1'b0;
                end
            end
        end
        // only our own pattern on the lines counts as a win
        win = (~bus.arb_n == prio_sw_i);
    end

    // ----------------------------------------
    // handover sequencing
    // ----------------------------------------
    // one counter serves setup, overlap and done hold in turn
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.win_s1 = win;
        d.win_s2 = q.win_s1;
        d.ack_s1 = bus.hlda;
        d.ack_s2 = q.ack_s1;
        d.ack_q2 = q.ack_s2;
        d.hold_s1 = ~bus.hold_n;
        d.hold_s2 = q.hold_s1;
        case (q.st)
            ST_IDLE: begin
                // a busy bus is waited out silently
                if (bus_needed_i && !q.ack_s2 && !q.hold_s2 && !q.req) begin
                    d.st = ST_ARB;
                    d.req = 1'b1;
                    d.drive = 1'b1;
                end
            end
            ST_ARB: begin
                if (!bus_needed_i) begin
                    d.req = 1'b0;
                    d.st = ST_WAIT;
                end else if (q.ack_s2 && !q.ack_q2) begin
                    if (q.win_s2) begin
                        d.st = ST_SETUP;
                        d.cnt = cnt_t'(`TMB_SETUP_CYC);
                    end else begin
                        // a loss drops only the request; bits stay until ack falls
                        d.req = 1'b0;
                        d.st = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // losers keep surviving bits until acknowledge falls
                if (!q.ack_s2) begin
                    d.drive = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            ST_SETUP: begin
                if (q.cnt != 4'h0) begin
                    // margin lets the lender finish its last cycle
                    d.cnt = q.cnt - 4'h1;
                end else begin
                    d.asd_dis = 1'b1;
                    d.ctl_en = 1'b1;
                    d.cnt = cnt_t'(`TMB_OVERLAP_CYC);
                    d.st = ST_XS_IN;
                end
            end
            ST_XS_IN: begin
                if (q.cnt != 4'h0) begin
                    // both sets of control drivers on, at idle levels
                    d.cnt = q.cnt - 4'h1;
                end else begin
                    // falls on a clock edge so it can start the first cycle
                    d.ctl_dis = 1'b1;
                    d.start = 1'b1;
                    d.st = ST_MINE;
                end
            end
            ST_MINE: begin
                // no hand back between cycles, only once all are done
                if (cycles_done_i) begin
                    d.cnt = cnt_t'(`TMB_DONE_HOLD_CYC);
                    d.st = ST_XS_OUT;
                end
            end
            ST_XS_OUT: begin
                // done hold first, then control released, then a second
                // overlap before the other disables let go
                if (q.ctl_dis && q.cnt != 4'h0) begin
                    d.cnt = q.cnt - 4'h1;
                end else if (q.ctl_dis) begin
                    d.ctl_dis = 1'b0;
                    d.cnt = cnt_t'(`TMB_OVERLAP_CYC);
                end else if (q.cnt != 4'h0) begin
                    d.cnt = q.cnt - 4'h1;
                end else begin
                    // request, disables and control drivers let go together
                    d.asd_dis = 1'b0;
                    d.ctl_en = 1'b0;
                    d.req = 1'b0;
                    d.st = ST_WAIT;
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // reset frees every line at once, even with a cycle in flight
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '{st:      ST_IDLE,
                   cnt:     4'h0,
                   default: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // bus outputs
    // ----------------------------------------
    // enables, not levels: the bus resolves the open collector pull-downs
    assign bus.hold_oe = q.req;
    assign bus.arb_oe = (q.drive ? prio_sw_i & keep : 4'h0);
    assign bus.adsb_n = ~q.asd_dis;
    assign bus.sdsb_n = ~q.asd_dis;
    assign bus.dodsb_n = ~q.asd_dis;
    assign bus.cdsb_n = ~q.ctl_dis;
    assign bus.tm_ctl_en = q.ctl_en;
    assign bus.tm_asd_en = q.ctl_dis;
    // control lines parked at overlap levels; real cycles come from
    // the user logic once mine_o is high
    assign bus.tm_sync = 1'b0;
    assign bus.tm_stval_n = 1'b1;
    assign bus.tm_dbin = 1'b0;
    assign bus.tm_wr_n = 1'b1;

    // ----------------------------------------
    // local outputs
    // ----------------------------------------
    assign mine_o = q.ctl_dis;
    assign cycle_start_o = q.start;
endmodule
`default_nettype wire

/* File: tmb_map.svh */
// Operation
// - first handover asserts address, status, data disables
// - overlap levels: sync low, strobes idle, ack high
// - control disable ends first handover, cycles start
// - run cycles; hand back only via second handover
// - releasing control disable starts second handover
// - release disables and hold request; back to idle
// - disables wait minimum time after acknowledge rise
// - driver overlap lasts at least a minimum
// - control disable asserted on rising clock edge
// - done waits for last cycle hold times
// - reverse transfer completes before acknowledge drops
// - drive priority on four active-low open-collector lines
// - on disagreement withdraw lower bits, keep higher
// - comparison is continuous parallel combinational logic
// - line three most significant, line zero least
// - request only when ack low and hold idle
// - settled winner takes bus on acknowledge rise
// - keep surviving priority bits until acknowledge falls
// - winner holds priority and request until done
// - loser drops request, keeps bits, retries later
// - drop hold request when bus no longer needed
// - priority from user switches via open collector
`ifndef TMB_MAP_SVH
`define TMB_MAP_SVH
`define TMB_PRIO_W            4
`define TMB_CLK_NS            40
`define TMB_SETUP_NS          80
`define TMB_OVERLAP_NS        80
`define TMB_DONE_HOLD_NS      80
`define TMB_REL_NS            80
`define TMB_CYC(ns)           ((ns + `TMB_CLK_NS - 1) / `TMB_CLK_NS)
`define TMB_SETUP_CYC         `TMB_CYC(`TMB_SETUP_NS)
`define TMB_OVERLAP_CYC       `TMB_CYC(`TMB_OVERLAP_NS)
`define TMB_DONE_HOLD_CYC     `TMB_CYC(`TMB_DONE_HOLD_NS)
`define TMB_REL_CYC           `TMB_CYC(`TMB_REL_NS)
`define TMB_SETTLE_CYC        2
`define TMB_CNT_W             4
`endif

/* File: tmb_pkg.sv */
package tmb_pkg;
    typedef logic [3:0] prio_t;
    typedef logic [3:0] cnt_t;
    typedef enum logic [6:0] {
        ST_IDLE     = 7'b000_0001,
        ST_ARB      = 7'b000_0010,
        ST_WAIT     = 7'b000_0100,
        ST_SETUP    = 7'b000_1000,
        ST_XS_IN    = 7'b001_0000,
        ST_MINE     = 7'b010_0000,
        ST_XS_OUT   = 7'b100_0000
    } tm_state_e;
    typedef enum logic [2:0] {
        PM_OWN      = 3'b001,
        PM_HOLD     = 3'b010,
        PM_DROP     = 3'b100
    } pm_state_e;
endpackage

/* File: tmb_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tmb_if;
    // hold request and arbitration lines are open collector, active low
    logic       hold_oe;
    logic       hold_n;
    logic [3:0] arb_oe;
    logic [3:0] arb_n;
    logic       hlda;
    logic       adsb_n;
    logic       sdsb_n;
    logic       dodsb_n;
    logic       cdsb_n;
    logic       tm_ctl_en;
    logic       tm_asd_en;
    logic       pm_ctl_en;
    logic       pm_asd_en;
    logic       pm_sync;
    logic       pm_stval_n;
    logic       pm_dbin;
    logic       pm_wr_n;
    logic       tm_sync;
    logic       tm_stval_n;
    logic       tm_dbin;
    logic       tm_wr_n;
    always_comb hold_n = ~hold_oe;
    always_comb arb_n = ~arb_oe;
    modport temp (output hold_oe, arb_oe, adsb_n, sdsb_n, dodsb_n, cdsb_n, tm_ctl_en,
                  tm_asd_en, tm_sync, tm_stval_n, tm_dbin, tm_wr_n,
                  input hold_n, arb_n, hlda);
    modport perm (output hlda, pm_ctl_en, pm_asd_en, pm_sync, pm_stval_n, pm_dbin,
                  pm_wr_n, input hold_n, adsb_n, sdsb_n, dodsb_n, cdsb_n);
endinterface
`default_nettype wire

/* File: tmb_perm.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tmb_map.svh"
module tmb_perm (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic hold_grant_i,
    tmb_if.perm       bus,
    output logic      bus_lent_o
);
    import tmb_pkg::*;
    typedef struct packed {
        pm_state_e st;
        cnt_t      cnt;
        logic      hlda;
        logic      ctl_en;
        logic      asd_en;
        logic      lent;
        logic      hold_s1;
        logic      hold_s2;
    } pm_s;
    pm_s q, d;
    always_comb begin
        d = q;
        d.hold_s1 = ~bus.hold_n;
        d.hold_s2 = q.hold_s1;
        d.ctl_en = bus.cdsb_n;
        d.asd_en = bus.adsb_n & bus.sdsb_n & bus.dodsb_n;
        case (q.st)
            PM_OWN: begin
                if (q.hold_s2 && hold_grant_i) begin
                    d.st = PM_HOLD;
                    d.hlda = 1'b1;
                end
            end
            PM_HOLD: begin
                d.lent = 1'b1;
                if (!q.hold_s2 && bus.adsb_n && bus.cdsb_n) begin
                    d.st = PM_DROP;
                    d.cnt = cnt_t'(`TMB_REL_CYC);
                end
            end
            PM_DROP: begin
                // wait out release margin before acknowledge falls
                if (q.cnt != 4'h0) begin
                    d.cnt = q.cnt - 4'h1;
                end else begin
                    d.hlda = 1'b0;
                    d.lent = 1'b0;
                    d.st = PM_OWN;
                end
            end
            default: d.st = PM_OWN;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '{st: PM_OWN, cnt: 4'h0, hlda: 1'b0, ctl_en: 1'b1, asd_en: 1'b1,
                   lent: 1'b0, hold_s1: 1'b0, hold_s2: 1'b0};
        end else begin
            q <= d;
        end
    end
    // control lines idle at overlap levels while lent
    assign bus.hlda = q.hlda;
    assign bus.pm_ctl_en = q.ctl_en;
    assign bus.pm_asd_en = q.asd_en;
    assign bus.pm_sync = 1'b0;
    assign bus.pm_stval_n = 1'b1;
    assign bus.pm_dbin = 1'b0;
    assign bus.pm_wr_n = 1'b1;
    assign bus_lent_o = q.lent;
endmodule
`default_nettype wire

/* File: tmb_props.sv */
`timescale 1ns/1ns
`default_nettype none
module tmb_props (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic       hold_oe,
    input wire logic       hold_n,
    input wire logic [3:0] arb_oe,
    input wire logic       hlda,
    input wire logic       adsb_n,
    input wire logic       sdsb_n,
    input wire logic       dodsb_n,
    input wire logic       cdsb_n,
    input wire logic       tm_ctl_en,
    input wire logic       tm_asd_en,
    input wire logic       pm_ctl_en,
    input wire logic       tm_sync,
    input wire logic       tm_stval_n,
    input wire logic       tm_dbin,
    input wire logic       tm_wr_n
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------
    // handover sequencing
    // ----------------------------------------
    xs_in_set_a: assert property ($fell(adsb_n) |-> !sdsb_n && !dodsb_n && tm_ctl_en)
        else $error("disables not asserted together");
    overlap_level_a: assert property (tm_ctl_en && pm_ctl_en |->
        !tm_sync && tm_stval_n && !tm_dbin && tm_wr_n && hlda) else $error("bad overlap levels");
    xs_in_end_a: assert property ($fell(cdsb_n) |-> tm_asd_en ##[0:3] !pm_ctl_en)
        else $error("control disable did not swap drivers");
    setup_gap_a: assert property ($fell(adsb_n) |-> $past(hlda, 2))
        else $error("disables too soon after acknowledge");
    overlap_min_a: assert property ($fell(cdsb_n) |-> $past(tm_ctl_en, 2) && $past(pm_ctl_en, 2))
        else $error("driver overlap too short");
    hold_kept_a: assert property (!cdsb_n |-> hold_oe)
        else $error("request dropped while owning bus");
    xs_out_a: assert property ($rose(cdsb_n) |-> !adsb_n && tm_ctl_en ##[0:1] !tm_asd_en)
        else $error("second handover entered wrongly");
    xs_out_end_a: assert property ($rose(adsb_n) |->
        sdsb_n && dodsb_n && !tm_ctl_en && !hold_oe && hlda) else $error("second handover end");
    ack_drop_a: assert property ($fell(hlda) |-> $past(adsb_n, 2))
        else $error("acknowledge dropped before release");
    req_gate_a: assert property ($rose(hold_oe) |-> !$past(hlda) && $past(hold_n))
        else $error("request raised while bus busy");
    arb_hold_a: assert property (hlda && $past(hlda) |-> $stable(arb_oe))
        else $error("priority changed under acknowledge");
    cover property ($fell(cdsb_n));
    cover property ($rose(adsb_n));
    cover property (hold_oe && !hlda ##10 !hlda);
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tmb_pkg::*;
    logic  clk_sys_i = 1'b0;
    logic  sys_rst_i = 1'b1;
    logic  need = 1'b0;
    logic  done = 1'b0;
    logic  grant = 1'b1;
    prio_t prio = 4'h0;
    logic  mine;
    logic  cstart;
    logic  lent;
    int    n_mismatch = 0;
    int    checks_done = 0;
    tmb_if bus ();
    always #20 clk_sys_i = ~clk_sys_i;
    tmb_temp u_tmb_temp (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus_needed_i(need),
        .prio_sw_i(prio), .cycles_done_i(done), .bus(bus), .mine_o(mine), .cycle_start_o(cstart));
    tmb_perm u_tmb_perm (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hold_grant_i(grant),
        .bus(bus), .bus_lent_o(lent));
    tmb_props u_tmb_props (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hold_oe(bus.hold_oe),
        .hold_n(bus.hold_n), .arb_oe(bus.arb_oe), .hlda(bus.hlda), .adsb_n(bus.adsb_n),
        .sdsb_n(bus.sdsb_n), .dodsb_n(bus.dodsb_n), .cdsb_n(bus.cdsb_n),
        .tm_ctl_en(bus.tm_ctl_en), .tm_asd_en(bus.tm_asd_en), .pm_ctl_en(bus.pm_ctl_en),
        .tm_sync(bus.tm_sync), .tm_stval_n(bus.tm_stval_n), .tm_dbin(bus.tm_dbin),
        .tm_wr_n(bus.tm_wr_n));
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check_idle();
        chk("request", {bus.hold_oe, bus.hlda}, 4'h0);
        chk("arb_oe", bus.arb_oe, 4'h0);
        chk("disables", {bus.adsb_n, bus.sdsb_n, bus.dodsb_n, bus.cdsb_n}, 4'hf);
        chk("mine", mine, 4'h0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_transfer(input prio_t p, input int busy);
        int i;
        prio = p;
        need = 1'b1;
        for (i = 0; i < 40 && mine !== 1'b1; i++) @(negedge clk_sys_i);
        chk("mine", mine, 4'h1);
        chk("cycle_start", cstart, 4'h1);
        chk("cdsb_n", bus.cdsb_n, 4'h0);
        chk("arb_n", bus.arb_n, ~p);
        chk("hold_n", bus.hold_n, 4'h0);
        @(negedge clk_sys_i);
        chk("cycle_start", cstart, 4'h0);
        chk("drv_swap", {bus.pm_asd_en, bus.tm_asd_en, bus.pm_ctl_en}, 4'h2);
        repeat (busy) @(negedge clk_sys_i);
        chk("owning", {mine, bus.hlda, lent}, 4'h7);
        need = 1'b0;
        done = 1'b1;
        @(negedge clk_sys_i);
        done = 1'b0;
        for (i = 0; i < 40 && bus.adsb_n !== 1'b1; i++) @(negedge clk_sys_i);
        chk("released", {bus.hold_n, bus.tm_ctl_en, bus.hlda}, 4'h5);
        for (i = 0; i < 40 && bus.hlda !== 1'b0; i++) @(negedge clk_sys_i);
        repeat (4) @(negedge clk_sys_i);
        chk("arb_oe", bus.arb_oe, 4'h0);
        chk("drv_back", {bus.pm_ctl_en, bus.pm_asd_en, bus.tm_ctl_en, bus.tm_asd_en}, 4'hc);
        chk("mine", mine, 4'h0);
    endtask
    task automatic t_no_grant(input prio_t p);
        grant = 1'b0;
        prio = p;
        need = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        chk("hold_n", bus.hold_n, 4'h0);
        chk("arb_n", bus.arb_n, ~p);
        chk("disables", {bus.adsb_n, bus.cdsb_n, bus.hlda, mine}, 4'hc);
        grant = 1'b1;
        t_transfer(p, 3);
    endtask
    task automatic t_midreset(input prio_t p);
        int i;
        prio = p;
        need = 1'b1;
        for (i = 0; i < 40 && mine !== 1'b1; i++) @(negedge clk_sys_i);
        sys_rst_i = 1'b1;
        need = 1'b0;
        @(negedge clk_sys_i);
        check_idle();
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask
    initial begin
        repeat (4) @(negedge clk_sys_i);
        check_idle();
        sys_rst_i = 1'b0;
        @(negedge clk_sys_i);
        t_transfer(4'h9, 0);
        t_transfer(4'h6, 6);
        t_transfer(4'hf, 2);
        t_no_grant(4'h5);
        t_midreset(4'ha);
        t_transfer(4'h0, 1);
        test_done();
    end
    // whole run needs well under 1000 cycles
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
